// file: design/pfmux_regs.svh
// Constants for the port pin function multiplexer
`ifndef PFMUX_REGS_SVH
`define PFMUX_REGS_SVH

// Control register select codes
`define PFMUX_IDX_PORT2_DIR   3'h0
`define PFMUX_IDX_PORT2_SEL   3'h1
`define PFMUX_IDX_PORT3_DIR   3'h2
`define PFMUX_IDX_PORT3_SEL   3'h3
`define PFMUX_IDX_PORT4_DIR   3'h4
`define PFMUX_IDX_PORT4_SEL   3'h5
`define PFMUX_IDX_ANALOG_EN   3'h6
`define PFMUX_IDX_OSC_RES     3'h7

// Reset values
`define PFMUX_RST_PORT2_SEL   8'hC0
`define PFMUX_RST_ZERO        8'h00

// Analog enable bit positions
`define PFMUX_AE_P2_4         4
`define PFMUX_AE_P3_0         5
`define PFMUX_AE_P3_6         6
`define PFMUX_AE_P3_7         7

// Oscillator resistor select bit position
`define PFMUX_OSC_RES_BIT     0

`endif

// file: design/pfmux_pkg.sv
// Types for the port pin function multiplexer
`include "pfmux_regs.svh"

package pfmux_pkg;

  typedef enum logic [2:0] {
    REG_PORT2_DIR = `PFMUX_IDX_PORT2_DIR,
    REG_PORT2_SEL = `PFMUX_IDX_PORT2_SEL,
    REG_PORT3_DIR = `PFMUX_IDX_PORT3_DIR,
    REG_PORT3_SEL = `PFMUX_IDX_PORT3_SEL,
    REG_PORT4_DIR = `PFMUX_IDX_PORT4_DIR,
    REG_PORT4_SEL = `PFMUX_IDX_PORT4_SEL,
    REG_ANALOG_EN = `PFMUX_IDX_ANALOG_EN,
    REG_OSC_RES   = `PFMUX_IDX_OSC_RES
  } pfmux_reg_t;

  typedef logic [7:0] pfmux_byte_t;

endpackage

// file: design/pfmux_top.sv
// Pin function multiplexer for port 2 pins 4-7, port 3 and port 4 pins 0-2
// Notes on behaviour
// - Reset selects GPIO everywhere except port 2 pins 6, 7 as crystal pins.
// - Select 0 and analog 0 gives GPIO; direction 0 input, 1 output.
// - P2.4 outputs timer A compare 2 on select and direction; analog 4 wins.
// - Analog enable turns off the pin's output driver and Schmitt trigger.
// - P2.5: select-only is nothing, select+direction drives ground, resistor select wins.
// - P2.6 is crystal input when selected, otherwise GPIO.
// - P2.7 is crystal output when selected, otherwise GPIO.
// - P3.0 carries serial B select or serial A clock; analog 5 wins.
// - Serial functions on port 3 take direction from the serial module.
// - Serial A clock on P3.0 forces serial B into 3-wire mode.
// - Serial B clock on P3.3 forces serial A into 3-wire mode.
// - Port 3 pins 1 to 5 carry their serial signals when selected.
// - P3.6, P3.7 are analog inputs 6, 7 when enabled, else GPIO.
// - Port 4 pins 0-2 selected: capture input on dir 0, compare out on dir 1.
`timescale 1ns/10ps
`include "pfmux_regs.svh"

module pfmux_top
  import pfmux_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        power_up_clear,
  // Control register access
  input  wire logic        ctrl_wr_en,
  input  wire pfmux_reg_t  ctrl_sel,
  input  wire pfmux_byte_t ctrl_wdata,
  output logic [7:0]       ctrl_rdata,
  // Port output values from the core
  input  wire logic [7:4]  port2_out_value,
  input  wire logic [7:0]  port3_out_value,
  input  wire logic [2:0]  port4_out_value,
  // Peripheral signals towards the pins
  input  wire logic        timer_a_compare_out2,
  input  wire logic [2:0]  timer_b_compare_out,
  input  wire logic [5:0]  serial_pin_out,
  input  wire logic [5:0]  serial_pin_oe,
  input  wire logic        serial_a_clock_active,
  input  wire logic        serial_b_clock_active,
  // Pad inputs
  input  wire logic [7:4]  p2_pad_in,
  input  wire logic [7:0]  p3_pad_in,
  input  wire logic [2:0]  p4_pad_in,
  // Pad controls
  output logic [7:4]       p2_pad_out,
  output logic [7:4]       p2_pad_oe,
  output logic [7:4]       p2_schmitt_en,
  output logic [7:0]       p3_pad_out,
  output logic [7:0]       p3_pad_oe,
  output logic [7:0]       p3_schmitt_en,
  output logic [2:0]       p4_pad_out,
  output logic [2:0]       p4_pad_oe,
  // Analog and oscillator connections
  output logic [7:4]       analog_channel_connect,
  output logic             external_resistor_pin,
  output logic             crystal_input,
  output logic             crystal_output,
  // Values back to the core and peripherals
  output logic [7:4]       port2_in_value,
  output logic [7:0]       port3_in_value,
  output logic [2:0]       port4_in_value,
  output logic [2:0]       timer_b_capture_in,
  output logic [5:0]       serial_pin_in,
  output logic             serial_a_force_3wire,
  output logic             serial_b_force_3wire
);

  // GPIO drive: {oe, out}
  function automatic logic [1:0] pfmux_gpio(input logic dir, input logic val);
    pfmux_gpio = {dir, val & dir};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  pfmux_byte_t port2_direction_bits_q, port2_function_select_q, port3_direction_bits_q, port3_function_select_q, port4_direction_bits_q, port4_function_select_q, ae_q, osc_q;
  pfmux_byte_t port2_direction_bits_d, port2_function_select_d, port3_direction_bits_d, port3_function_select_d, port4_direction_bits_d, port4_function_select_d, ae_d, osc_d;
  logic [7:0]  rdata_q, rdata_d;

  always_comb begin
    {port2_direction_bits_d, port2_function_select_d, port3_direction_bits_d, port3_function_select_d} = {port2_direction_bits_q, port2_function_select_q, port3_direction_bits_q, port3_function_select_q};
    {port4_direction_bits_d, port4_function_select_d, ae_d, osc_d} = {port4_direction_bits_q, port4_function_select_q, ae_q, osc_q};
    if (power_up_clear) begin
      {port2_direction_bits_d, port3_direction_bits_d, port3_function_select_d, port4_direction_bits_d} = {4{`PFMUX_RST_ZERO}};
      {port4_function_select_d, ae_d, osc_d} = {3{`PFMUX_RST_ZERO}};
      port2_function_select_d = `PFMUX_RST_PORT2_SEL;
    end else if (ctrl_wr_en) begin
      case (ctrl_sel)
        REG_PORT2_DIR: port2_direction_bits_d = ctrl_wdata;
        REG_PORT2_SEL: port2_function_select_d = ctrl_wdata;
        REG_PORT3_DIR: port3_direction_bits_d = ctrl_wdata;
        REG_PORT3_SEL: port3_function_select_d = ctrl_wdata;
        REG_PORT4_DIR: port4_direction_bits_d = ctrl_wdata;
        REG_PORT4_SEL: port4_function_select_d = ctrl_wdata;
        REG_ANALOG_EN: ae_d    = ctrl_wdata;
        REG_OSC_RES:   osc_d   = ctrl_wdata & 8'h01;
        default:       ;
      endcase
    end
    case (ctrl_sel)
      REG_PORT2_DIR: rdata_d = port2_direction_bits_d;
      REG_PORT2_SEL: rdata_d = port2_function_select_d;
      REG_PORT3_DIR: rdata_d = port3_direction_bits_d;
      REG_PORT3_SEL: rdata_d = port3_function_select_d;
      REG_PORT4_DIR: rdata_d = port4_direction_bits_d;
      REG_PORT4_SEL: rdata_d = port4_function_select_d;
      REG_ANALOG_EN: rdata_d = ae_d;
      REG_OSC_RES:   rdata_d = osc_d;
      default:       rdata_d = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode, computed from the next control values so a write reaches the
  // pin at the same edge that stores it
  logic [7:4] p2o_d, p2e_d, p2s_d, an_d, p2i_d;
  logic [7:0] p3o_d, p3e_d, p3s_d, p3i_d;
  logic [2:0] p4o_d, p4e_d, p4i_d, tbc_d;
  logic [5:0] ser_d;
  logic       res_d, xin_d, crystal_output_d, fa_d, fb_d;

  always_comb begin
    {p2e_d[4], p2o_d[4]} = pfmux_gpio(port2_direction_bits_d[4], port2_out_value[4]);
    {p2e_d[5], p2o_d[5]} = pfmux_gpio(port2_direction_bits_d[5], port2_out_value[5]);
    {p2e_d[6], p2o_d[6]} = pfmux_gpio(port2_direction_bits_d[6], port2_out_value[6]);
    {p2e_d[7], p2o_d[7]} = pfmux_gpio(port2_direction_bits_d[7], port2_out_value[7]);
    p2s_d  = 4'hF;
    an_d   = 4'h0;
    res_d  = 1'b0;
    xin_d  = 1'b0;
    crystal_output_d = 1'b0;
    // Port 2 pin 4
    if (ae_d[`PFMUX_AE_P2_4]) begin
      {p2e_d[4], p2o_d[4], p2s_d[4], an_d[4]} = 4'h1;
    end else if (port2_function_select_d[4]) begin
      p2e_d[4] = port2_direction_bits_d[4];
      p2o_d[4] = timer_a_compare_out2 & port2_direction_bits_d[4];
    end
    // Port 2 pin 5: the resistor pin is analog, so its Schmitt trigger is off too
    if (osc_d[`PFMUX_OSC_RES_BIT]) begin
      {p2e_d[5], p2o_d[5], p2s_d[5], res_d} = 4'h1;
    end else if (port2_function_select_d[5]) begin
      p2e_d[5] = port2_direction_bits_d[5];
      p2o_d[5] = 1'b0;
    end
    // Crystal pins: the oscillator owns them while selected
    if (port2_function_select_d[6]) begin
      {p2e_d[6], p2o_d[6], p2s_d[6], xin_d} = 4'h1;
    end
    if (port2_function_select_d[7]) begin
      {p2e_d[7], p2o_d[7], p2s_d[7], crystal_output_d} = 4'h1;
    end
    p2i_d = p2_pad_in & p2s_d;
    // Port 3
    p3s_d = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      {p3e_d[i], p3o_d[i]} = pfmux_gpio(port3_direction_bits_d[i], port3_out_value[i]);
    end
    for (int i = 0; i < 6; i++) begin
      ser_d[i] = 1'b0;
      if (port3_function_select_d[i]) begin
        p3e_d[i] = serial_pin_oe[i];
        p3o_d[i] = serial_pin_out[i] & serial_pin_oe[i];
        ser_d[i] = p3_pad_in[i];
      end
    end
    if (ae_d[`PFMUX_AE_P3_0]) begin
      {p3e_d[0], p3o_d[0], p3s_d[0], ser_d[0]} = 4'h0;
      an_d[5] = 1'b1;
    end
    if (ae_d[`PFMUX_AE_P3_6]) begin
      {p3e_d[6], p3o_d[6], p3s_d[6]} = 3'h0;
      an_d[6] = 1'b1;
    end
    if (ae_d[`PFMUX_AE_P3_7]) begin
      {p3e_d[7], p3o_d[7], p3s_d[7]} = 3'h0;
      an_d[7] = 1'b1;
    end
    p3i_d = p3_pad_in & p3s_d;
    // Clock functions outrank the select-line functions they share a pin with
    fb_d = port3_function_select_d[0] & ~ae_d[`PFMUX_AE_P3_0] & serial_a_clock_active;
    fa_d = port3_function_select_d[3] & serial_b_clock_active;
    // Port 4
    for (int i = 0; i < 3; i++) begin
      {p4e_d[i], p4o_d[i]} = pfmux_gpio(port4_direction_bits_d[i], port4_out_value[i]);
      tbc_d[i] = 1'b0;
      if (port4_function_select_d[i]) begin
        p4o_d[i] = timer_b_compare_out[i] & port4_direction_bits_d[i];
        tbc_d[i] = p4_pad_in[i] & ~port4_direction_bits_d[i];
      end
    end
    p4i_d = p4_pad_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:4] p2o_q, p2e_q, p2s_q, an_q, p2i_q;
  logic [7:0] p3o_q, p3e_q, p3s_q, p3i_q;
  logic [2:0] p4o_q, p4e_q, p4i_q, tbc_q;
  logic [5:0] ser_q;
  logic       res_q, xin_q, crystal_output_q, fa_q, fb_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {port2_direction_bits_q, port3_direction_bits_q, port3_function_select_q, port4_direction_bits_q} <= {4{`PFMUX_RST_ZERO}};
      {port4_function_select_q, ae_q, osc_q} <= {3{`PFMUX_RST_ZERO}};
      port2_function_select_q <= `PFMUX_RST_PORT2_SEL;
      rdata_q <= 8'h00;
      {p2o_q, p2e_q, an_q, p2i_q} <= 16'h0000;
      p2s_q   <= 4'h3;
      {p3o_q, p3e_q, p3i_q} <= 24'h000000;
      p3s_q   <= 8'hFF;
      {p4o_q, p4e_q, p4i_q, tbc_q} <= 12'h000;
      ser_q   <= 6'h00;
      {res_q, fa_q, fb_q} <= 3'h0;
      {xin_q, crystal_output_q} <= 2'h3;
    end else if (clk_en) begin
      {port2_direction_bits_q, port2_function_select_q, port3_direction_bits_q, port3_function_select_q} <= {port2_direction_bits_d, port2_function_select_d, port3_direction_bits_d, port3_function_select_d};
      {port4_direction_bits_q, port4_function_select_q, ae_q, osc_q} <= {port4_direction_bits_d, port4_function_select_d, ae_d, osc_d};
      rdata_q <= rdata_d;
      {p2o_q, p2e_q, p2s_q, an_q, p2i_q} <= {p2o_d, p2e_d, p2s_d, an_d, p2i_d};
      {p3o_q, p3e_q, p3s_q, p3i_q} <= {p3o_d, p3e_d, p3s_d, p3i_d};
      {p4o_q, p4e_q, p4i_q, tbc_q} <= {p4o_d, p4e_d, p4i_d, tbc_d};
      ser_q   <= ser_d;
      {res_q, xin_q, crystal_output_q, fa_q, fb_q} <= {res_d, xin_d, crystal_output_d, fa_d, fb_d};
    end
  end

  assign ctrl_rdata             = rdata_q;
  assign p2_pad_out             = p2o_q;
  assign p2_pad_oe              = p2e_q;
  assign p2_schmitt_en          = p2s_q;
  assign p3_pad_out             = p3o_q;
  assign p3_pad_oe              = p3e_q;
  assign p3_schmitt_en          = p3s_q;
  assign p4_pad_out             = p4o_q;
  assign p4_pad_oe              = p4e_q;
  assign analog_channel_connect = an_q;
  assign external_resistor_pin  = res_q;
  assign crystal_input          = xin_q;
  assign crystal_output         = crystal_output_q;
  assign port2_in_value         = p2i_q;
  assign port3_in_value         = p3i_q;
  assign port4_in_value         = p4i_q;
  assign timer_b_capture_in     = tbc_q;
  assign serial_pin_in          = ser_q;
  assign serial_a_force_3wire   = fa_q;
  assign serial_b_force_3wire   = fb_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_sel3_write;
    clk_en && ctrl_wr_en && !power_up_clear && ctrl_sel == REG_PORT3_SEL;
  endsequence

  a_reset_crystal: assert property ($rose(reset_n) |-> xin_q && crystal_output_q && port2_function_select_q == 8'hC0
    && port3_function_select_q == 8'h00) else $error("crystal pins not selected after reset");
  a_gpio_direction: assert property (!ae_q[6] |-> p3e_q[6] == port3_direction_bits_q[6])
    else $error("P3.6 drive does not follow direction");
  a_timer_a_drive: assert property (port2_function_select_q[4] && port2_direction_bits_q[4] && !ae_q[4] |-> p2e_q[4])
    else $error("P2.4 timer output not driven");
  a_analog_pin_off: assert property (ae_q[4] |-> !p2e_q[4] && !p2s_q[4] && an_q[4])
    else $error("analog pin still digital");
  a_resistor_pin: assert property (osc_q[0] |-> res_q && !p2e_q[5])
    else $error("resistor pin not connected");
  a_ground_drive: assert property (port2_function_select_q[5] && port2_direction_bits_q[5] && !osc_q[0] |-> p2e_q[5]
    && !p2o_q[5]) else $error("P2.5 not driving ground");
  a_crystal_in: assert property (port2_function_select_q[6] |-> xin_q && !p2e_q[6])
    else $error("crystal input not connected");
  a_crystal_out: assert property (port2_function_select_q[7] == crystal_output_q)
    else $error("crystal output mismatch");
  a_p30_analog: assert property (ae_q[5] |-> an_q[5] && !p3e_q[0])
    else $error("P3.0 analog connect wrong");
  a_serial_dir: assert property ($past(clk_en) && port3_function_select_q[1] |-> p3e_q[1] ==
    $past(serial_pin_oe[1])) else $error("serial pin direction wrong");
  a_force_b_3wire: assert property ($past(clk_en) && port3_function_select_q[0] && !ae_q[5] &&
    $past(serial_a_clock_active) |-> fb_q) else $error("serial B not forced");
  a_force_a_3wire: assert property ($past(clk_en) && port3_function_select_q[3] &&
    $past(serial_b_clock_active) |-> fa_q) else $error("serial A not forced");
  a_timer_b_out: assert property ($past(clk_en) && port4_function_select_q[0] && port4_direction_bits_q[0] |->
    p4o_q[0] == $past(timer_b_compare_out[0])) else $error("timer B out wrong");
  a_write_applies: assert property (s_sel3_write |=> port3_function_select_q == $past(ctrl_wdata) &&
    p3e_q[2] == (port3_function_select_q[2] ? $past(serial_pin_oe[2]) : port3_direction_bits_q[2]))
    else $error("select write not applied");

endmodule

// file: test/pfmux_top_tb_top.sv
// Self-checking testbench for the port pin function multiplexer
`timescale 1ns/10ps

module pfmux_top_tb_top
  import pfmux_pkg::*;
;
  typedef struct {
    string      nm;
    logic [7:0] ex;
    longint     due;
  } pfmux_note_t;

  logic        ref_clk, reset_n, clk_en, power_up_clear, ctrl_wr_en;
  pfmux_reg_t  ctrl_sel;
  pfmux_byte_t ctrl_wdata;
  logic [7:0]  ctrl_rdata, port3_out_value, p3_pad_in, p3_pad_out, p3_pad_oe, p3_schmitt_en;
  logic [7:0]  port3_in_value;
  logic [7:4]  port2_out_value, p2_pad_in, p2_pad_out, p2_pad_oe, p2_schmitt_en;
  logic [7:4]  analog_channel_connect, port2_in_value;
  logic [2:0]  port4_out_value, timer_b_compare_out, p4_pad_in, p4_pad_out, p4_pad_oe;
  logic [2:0]  port4_in_value, timer_b_capture_in;
  logic [5:0]  serial_pin_out, serial_pin_oe, serial_pin_in;
  logic        timer_a_compare_out2, serial_a_clock_active, serial_b_clock_active;
  logic        external_resistor_pin, crystal_input, crystal_output;
  logic        serial_a_force_3wire, serial_b_force_3wire;
  pfmux_note_t nq[$];
  longint      cyc = 0;
  int          miscompares = 0;
  int          checks_done = 0;

  pfmux_top dut (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Drive helpers
  task automatic step();
    @(posedge ref_clk);
    #5;
  endtask

  // Write strobe is held between back-to-back writes; go() drops it
  task automatic wr(pfmux_reg_t r, logic [7:0] v);
    ctrl_sel = r;
    ctrl_wdata = v;
    ctrl_wr_en = 1'b1;
    step();
  endtask

  task automatic go();
    ctrl_wr_en = 1'b0;
    step();
  endtask

  // Outputs are registered, so a note is due one edge after the stimulus
  task automatic note(string n, logic [7:0] v);
    nq.push_back('{n, v, cyc + 1});
  endtask

  function automatic logic [7:0] probe(string n);
    case (n)
      "rdata": return ctrl_rdata;
      "p2oe":  return {4'h0, p2_pad_oe};
      "p2drv": return {4'h0, p2_pad_out & p2_pad_oe};
      "p2st":  return {4'h0, p2_schmitt_en};
      "p3oe":  return p3_pad_oe;
      "p3drv": return p3_pad_out & p3_pad_oe;
      "p3st":  return p3_schmitt_en;
      "p3in":  return port3_in_value;
      "p2in":  return {4'h0, port2_in_value};
      "p4in":  return {5'h00, port4_in_value};
      "p4oe":  return {5'h00, p4_pad_oe};
      "p4drv": return {5'h00, p4_pad_out & p4_pad_oe};
      "cap":   return {5'h00, timer_b_capture_in};
      "spin":  return {2'h0, serial_pin_in};
      "ana":   return {analog_channel_connect, 4'h0};
      "osc":   return {5'h00, external_resistor_pin, crystal_input, crystal_output};
      "f3w":   return {6'h00, serial_a_force_3wire, serial_b_force_3wire};
      default: return 8'hXX;
    endcase
  endfunction

  task automatic test_done();
    // A note still waiting means an expected result never appeared
    if (nq.size() != 0)
      miscompares++;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: compares each due note against the settled outputs
  initial begin
    pfmux_note_t n;
    logic [7:0]  seen;
    forever begin
      @(negedge ref_clk);
      while (nq.size() > 0 && nq[0].due <= cyc) begin
        n = nq.pop_front();
        seen = probe(n.nm);
        checks_done++;
        if (seen !== n.ex) begin
          miscompares++;
          $display("mismatch %s expected %h seen %h", n.nm, n.ex, seen);
        end
      end
    end
  end

  // Whole run is under 70 cycles; the timeout is 4000 cycles
  initial begin
    #200000;
    miscompares++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    logic [7:0] d;
    logic [5:0] so, se;
    {power_up_clear, ctrl_wr_en, ctrl_wdata, port2_out_value, port3_out_value} = '0;
    {port4_out_value, timer_a_compare_out2, timer_b_compare_out, serial_pin_out} = '0;
    {serial_pin_oe, serial_a_clock_active, serial_b_clock_active} = '0;
    {p2_pad_in, p3_pad_in, p4_pad_in} = '0;
    ctrl_sel = REG_PORT2_SEL;
    clk_en = 1'b1;
    reset_n = 1'b0;
    void'($urandom(32'h43984261));
    repeat (16) step();
    reset_n = 1'b1;
    note("rdata", 8'hC0);
    note("osc", 8'h03);
    note("p2st", 8'h03);
    note("p3oe", 8'h00);
    go();
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom());
      wr(REG_PORT3_DIR, d);
      wr(REG_PORT4_DIR, d);
      port3_out_value = 8'($urandom());
      port4_out_value = 3'($urandom());
      p3_pad_in = 8'($urandom());
      p4_pad_in = 3'($urandom());
      note("p4in", {5'h00, p4_pad_in});
      note("p3oe", d);
      note("p3drv", port3_out_value & d);
      note("p3in", p3_pad_in);
      note("p4oe", {5'h00, d[2:0]});
      note("p4drv", {5'h00, port4_out_value & d[2:0]});
      go();
    end
    wr(REG_PORT2_SEL, 8'h10);
    wr(REG_PORT2_DIR, 8'hF0);
    timer_a_compare_out2 = 1'b1;
    note("p2oe", 8'h0F);
    note("p2drv", 8'h01);
    note("osc", 8'h00);
    go();
    wr(REG_ANALOG_EN, 8'h10);
    p2_pad_in = 4'hF;
    note("p2in", 8'h0E);
    note("ana", 8'h10);
    note("p2oe", 8'h0E);
    note("p2st", 8'h0E);
    go();
    wr(REG_ANALOG_EN, 8'h00);
    wr(REG_PORT2_SEL, 8'h30);
    timer_a_compare_out2 = 1'b0;
    port2_out_value = 4'h2;
    note("p2oe", 8'h0F);
    note("p2drv", 8'h00);
    go();
    wr(REG_PORT2_DIR, 8'hC0);
    note("p2oe", 8'h0C);
    go();
    wr(REG_PORT2_DIR, 8'hF0);
    wr(REG_OSC_RES, 8'hFF);
    note("rdata", 8'h01);
    note("osc", 8'h04);
    note("p2oe", 8'h0D);
    go();
    wr(REG_OSC_RES, 8'h00);
    wr(REG_PORT2_SEL, 8'hC0);
    note("osc", 8'h03);
    note("p2in", 8'h03);
    note("p2oe", 8'h03);
    go();
    wr(REG_PORT3_DIR, 8'hC0);
    wr(REG_PORT3_SEL, 8'h3F);
    so = 6'($urandom());
    se = 6'($urandom());
    serial_pin_out = so;
    serial_pin_oe = se;
    p3_pad_in = 8'($urandom());
    serial_a_clock_active = 1'b1;
    serial_b_clock_active = 1'b1;
    note("p3oe", {2'h3, se});
    note("p3drv", {port3_out_value[7:6], so & se});
    note("spin", {2'h0, p3_pad_in[5:0]});
    note("f3w", 8'h03);
    go();
    wr(REG_ANALOG_EN, 8'hE0);
    note("ana", 8'hE0);
    note("p3oe", {2'h0, se & 6'h3E});
    note("p3st", 8'h3E);
    note("spin", {2'h0, p3_pad_in[5:1], 1'b0});
    go();
    wr(REG_PORT3_SEL, 8'h00);
    wr(REG_ANALOG_EN, 8'h00);
    note("f3w", 8'h00);
    go();
    wr(REG_PORT4_SEL, 8'h07);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom());
      wr(REG_PORT4_DIR, d);
      timer_b_compare_out = 3'($urandom());
      p4_pad_in = 3'($urandom());
      note("p4oe", {5'h00, d[2:0]});
      note("p4drv", {5'h00, timer_b_compare_out & d[2:0]});
      note("cap", {5'h00, p4_pad_in & ~d[2:0]});
      go();
    end
    // With the enable low a write is lost and every output holds
    clk_en = 1'b0;
    note("rdata", d);
    note("p4drv", {5'h00, timer_b_compare_out & d[2:0]});
    timer_b_compare_out = ~timer_b_compare_out;
    wr(REG_PORT2_SEL, 8'h00);
    clk_en = 1'b1;
    note("rdata", 8'hC0);
    note("p4drv", {5'h00, timer_b_compare_out & d[2:0]});
    go();
    // A write during the clear is dropped, the defaults win
    power_up_clear = 1'b1;
    wr(REG_PORT2_SEL, 8'h00);
    power_up_clear = 1'b0;
    note("rdata", 8'hC0);
    note("osc", 8'h03);
    note("p4oe", 8'h00);
    note("p2oe", 8'h00);
    go();
    step();
    test_done();
  end
endmodule
